//--- hdl/icc_input_capture.sv
// Purpose: Three-channel input capture control, flags and event pulses
// Assumes: cap_in pins are asynchronous; software never programs edge code 11
// Notes: Registers reached over Avalon-MM with waitrequest, one wait cycle
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps

// Behaviour
// R1 - Three channels, enables at bits 6,5,4; edges ignored while disabled
// R2 - Selected edge sets channel flag at bits 2,1,0
// R3 - Hardware never clears a flag; software clears by writing zero
// R4 - Edge code 00 falling, 01 rising, 10 either edge
// R5 - Software must not program reserved edge code 11
// R6 - Edge fields at bits 5:4, 3:2, 1:0; upper bits unused
// R7 - Filter enables at bits 6,5,4 route input through noise filter
// R8 - Filter disabled means edges detected on unfiltered input
// R9 - Edge select register resets to all zeros
// R10 - Each detected edge issues a one-cycle capture pulse to the timer
module icc_input_capture
    import icc_pkg::*;
#(
    parameter int FILT_LEN = ICC_FILT_LEN
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ICC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ICC_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ICC_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [ICC_CHANNELS-1:0] cap_in,
    output logic [ICC_CHANNELS-1:0] cap_event,
    output logic irq
);

    logic waitreq_q, waitreq_d;
    logic [ICC_DATA_W-1:0] rdata_q, rdata_d;
    logic [2:0] en_q, en_d;
    logic [2:0] flag_q, flag_d;
    logic [5:0] kind_q, kind_d;
    logic [2:0] filt_q, filt_d;
    logic [2:0] ist_q, ist_d;
    logic [2:0] imask_q, imask_d;
    logic [2:0] event_q, event_d;
    logic irq_q, irq_d;
    logic [2:0] edge_hit;
    logic [2:0] lvl;
    logic [2:0] flt;
    logic [2:0] sel_lvl;
    logic [7:0] idx;
    logic aligned;
    logic wr_fire;
    logic rd_take;
    logic lane0;

    assign idx = avs_address[9:2];
    assign aligned = (avs_address[1:0] == 2'b00);
    // Write lands on the same edge at which the master sees waitrequest low
    assign wr_fire = avs_write && !waitreq_q && aligned;
    assign rd_take = avs_read && waitreq_q;
    assign lane0 = avs_byteenable[0];

    // Per-channel synchroniser, noise filter and edge detector
    genvar g;
    generate
        for (g = 0; g < ICC_CHANNELS; g++) begin : g_chan
            logic s1_q, s2_q, s3_q;
            logic lvl_q, lvl_d;
            logic flt_q, flt_d;
            logic prev_q;
            logic [ICC_FILT_CNT_W-1:0] cnt_q, cnt_d;
            logic sel, rise, fall, hit;
            icc_chan_cfg_type cfg;

            always_comb begin
                cfg.on = en_q[g];
                cfg.filter_on = filt_q[g];
                cfg.kind = icc_edge_type'(kind_q[g*ICC_KIND_W +: ICC_KIND_W]);
                // Level accepted only once stages two and three agree
                lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
                flt_d = flt_q;
                cnt_d = '0;
                if (lvl_q != flt_q) begin
                    if (cnt_q == ICC_FILT_CNT_W'(FILT_LEN - 1)) begin
                        flt_d = lvl_q;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                sel = cfg.filter_on ? flt_q : lvl_q; // see R7 see R8
                rise = sel && !prev_q;
                fall = !sel && prev_q;
                case (cfg.kind) // see R4
                    ICC_EDGE_FALL: hit = fall;
                    ICC_EDGE_RISE: hit = rise;
                    ICC_EDGE_BOTH: hit = rise || fall;
                    default: hit = 1'b0;
                endcase
                hit = hit && cfg.on; // see R1
            end

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                    flt_q <= 1'b0;
                    prev_q <= 1'b0;
                    cnt_q <= '0;
                end else begin
                    s1_q <= cap_in[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    lvl_q <= lvl_d;
                    flt_q <= flt_d;
                    prev_q <= sel;
                    cnt_q <= cnt_d;
                end
            end

            assign edge_hit[g] = hit;
            assign lvl[g] = lvl_q;
            assign flt[g] = flt_q;
            assign sel_lvl[g] = sel;

            // Pulse and flag must agree on every channel
            a_pulse_sets_flag: assert property (@(posedge clock) disable iff (rst) // see R2
                cap_event[g] |-> flag_q[g] && ist_q[g])
                else $error("capture pulse without its flag");

            a_off_no_pulse: assert property (@(posedge clock) disable iff (rst) // see R1
                !en_q[g] |=> !cap_event[g])
                else $error("capture pulse while channel disabled");
        end
    endgenerate

    // Register file and bus answer
    always_comb begin
        waitreq_d = 1'b1;
        rdata_d = rdata_q;
        en_d = en_q;
        kind_d = kind_q;
        filt_d = filt_q;
        imask_d = imask_q;
        flag_d = flag_q;
        ist_d = ist_q;
        // One wait cycle per request, then waitrequest low for one cycle
        if ((avs_read || avs_write) && waitreq_q) begin
            waitreq_d = 1'b0;
        end
        // Registered so the data stands through the low wait cycle
        if (rd_take) begin
            rdata_d = '0;
            if (aligned) begin
                case (idx)
                    ICC_IDX_ENFLAG: rdata_d[7:0] = {1'b0, en_q, 1'b0, flag_q};
                    ICC_IDX_EDGE: rdata_d[7:0] = {2'b00, kind_q}; // see R6
                    ICC_IDX_FILT: rdata_d[7:0] = {1'b0, filt_q, 4'h0};
                    ICC_IDX_IRQ_STAT: rdata_d[7:0] = {5'h00, ist_q};
                    ICC_IDX_IRQ_MASK: rdata_d[7:0] = {5'h00, imask_q};
                    default: rdata_d = '0;
                endcase
            end
        end
        if (wr_fire && lane0) begin
            case (idx)
                ICC_IDX_ENFLAG: begin
                    en_d = avs_writedata[ICC_EN_LSB +: 3];
                    // Writing one leaves a flag alone, zero clears it
                    flag_d = flag_q & avs_writedata[ICC_FLAG_LSB +: 3]; // see R3
                end
                ICC_IDX_EDGE: kind_d = avs_writedata[5:0]; // see R6 see R5
                ICC_IDX_FILT: filt_d = avs_writedata[ICC_FILT_LSB +: 3]; // see R7
                ICC_IDX_IRQ_STAT: ist_d = ist_q & ~avs_writedata[2:0];
                ICC_IDX_IRQ_MASK: imask_d = avs_writedata[2:0];
                default: ;
            endcase
        end
        // Set beats a clear arriving in the same cycle
        flag_d = flag_d | edge_hit; // see R2
        ist_d = ist_d | edge_hit;
        event_d = edge_hit; // see R10
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitreq_q <= 1'b1;
            rdata_q <= '0;
            en_q <= ICC_EN_RST;
            flag_q <= ICC_FLAG_RST;
            kind_q <= ICC_EDGE_RST; // see R9
            filt_q <= ICC_FILT_RST;
            ist_q <= ICC_IRQ_RST;
            imask_q <= ICC_IRQ_RST;
            event_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            waitreq_q <= waitreq_d;
            rdata_q <= rdata_d;
            en_q <= en_d;
            flag_q <= flag_d;
            kind_q <= kind_d;
            filt_q <= filt_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            event_q <= event_d;
            irq_q <= irq_d;
        end
    end

    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;
    assign cap_event = event_q;
    assign irq = irq_q;

    a_disabled_no_event: assert property (@(posedge clock) disable iff (rst) // see R1
        !en_q[1] |=> !event_q[1])
        else $error("event pulse from a disabled channel");

    a_edge_sets_flag: assert property (@(posedge clock) disable iff (rst) // see R2
        (edge_hit != 3'h0) |=> ((flag_q & $past(edge_hit)) == $past(edge_hit)))
        else $error("detected edge did not set its flag");

    a_flag_holds_set: assert property (@(posedge clock) disable iff (rst) // see R3
        (flag_q != 3'h0) && !(wr_fire && idx == ICC_IDX_ENFLAG)
        |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
        else $error("flag cleared without software write");

    a_rise_detect: assert property (@(posedge clock) disable iff (rst) // see R4
        en_q[1] && kind_q[3:2] == ICC_EDGE_RISE && $rose(sel_lvl[1]) |=> event_q[1])
        else $error("rising edge missed in rising mode");

    a_fall_ignores_rise: assert property (@(posedge clock) disable iff (rst) // see R4
        kind_q[1:0] == ICC_EDGE_FALL && $rose(sel_lvl[0]) |=> !event_q[0])
        else $error("rising edge reported in falling mode");

    a_edge_readback: assert property (@(posedge clock) disable iff (rst) // see R6
        avs_read && !waitreq_q && aligned && idx == ICC_IDX_EDGE
        |-> avs_readdata == {26'h0000000, kind_q})
        else $error("edge select readback wrong");

    a_filter_hold: assert property (@(posedge clock) disable iff (rst) // see R7
        filt_q[2] && $stable(filt_q[2]) && $changed(sel_lvl[2])
        |-> $past(lvl[2], 4) == sel_lvl[2] && $past(lvl[2]) == sel_lvl[2])
        else $error("filtered level changed before hold time");

    a_raw_path: assert property (@(posedge clock) disable iff (rst) // see R8
        !filt_q[0] && !$past(filt_q[0]) && en_q[0] && kind_q[1:0] == ICC_EDGE_FALL
        && $fell(lvl[0]) |=> event_q[0])
        else $error("unfiltered edge missed");

    a_edge_reset_zero: assert property (@(posedge clock) // see R9
        $fell(rst) |-> kind_q == 6'h00)
        else $error("edge select not zero after reset");

    a_event_one_cycle: assert property (@(posedge clock) disable iff (rst) // see R10
        event_q[2] |-> ist_q[2] ##1 !event_q[2])
        else $error("capture pulse longer than one cycle");

    a_irq_level: assert property (@(posedge clock) disable iff (rst)
        irq == |(ist_q & imask_q))
        else $error("interrupt level disagrees with status and mask");

    a_both_edges: assert property (@(posedge clock) disable iff (rst) // see R4
        en_q[2] && kind_q[5:4] == ICC_EDGE_BOTH && $changed(sel_lvl[2]) |=> event_q[2])
        else $error("edge missed in either-edge mode");

    a_flag_sw_clear: assert property (@(posedge clock) disable iff (rst) // see R3
        wr_fire && lane0 && idx == ICC_IDX_ENFLAG && edge_hit == 3'h0
        |=> flag_q == ($past(flag_q) & $past(avs_writedata[2:0])))
        else $error("flag write did not follow write-zero-to-clear");

    a_stat_w1c: assert property (@(posedge clock) disable iff (rst)
        wr_fire && lane0 && idx == ICC_IDX_IRQ_STAT && edge_hit == 3'h0
        |=> ist_q == ($past(ist_q) & ~$past(avs_writedata[2:0])))
        else $error("interrupt status write did not clear by ones");

    a_en_readback: assert property (@(posedge clock) disable iff (rst) // see R1
        avs_read && !waitreq_q && aligned && idx == ICC_IDX_ENFLAG
        |-> avs_readdata[6:4] == en_q)
        else $error("enable readback wrong");

    a_filt_readback: assert property (@(posedge clock) disable iff (rst) // see R7
        avs_read && !waitreq_q && aligned && idx == ICC_IDX_FILT
        |-> avs_readdata[6:4] == filt_q)
        else $error("filter enable readback wrong");

    a_upper_zero: assert property (@(posedge clock) disable iff (rst) // see R6
        avs_readdata[31:8] == 24'h000000)
        else $error("unused read data bits not zero");

    // Bus answers with exactly one wait cycle
    a_wait_drops: assert property (@(posedge clock) disable iff (rst)
        (avs_read || avs_write) && waitreq_q |=> !waitreq_q)
        else $error("waitrequest did not drop after one cycle");

    a_wait_short: assert property (@(posedge clock) disable iff (rst)
        !waitreq_q |=> waitreq_q)
        else $error("waitrequest low for more than one cycle");

endmodule

//--- include/icc_pkg.sv
// Purpose: Shared constants and types for the input capture control block
// Assumes: Avalon-MM slave with 32-bit data; byte address = 4 * register index
// Notes: Register data sits in bits 7:0, upper bits read zero
package icc_pkg;
    localparam int ICC_CHANNELS = 3;
    localparam int ICC_ADDR_W = 10;
    localparam int ICC_DATA_W = 32;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] ICC_IDX_ENFLAG = 8'h92;
    localparam logic [7:0] ICC_IDX_EDGE = 8'h93;
    localparam logic [7:0] ICC_IDX_FILT = 8'h94;
    localparam logic [7:0] ICC_IDX_IRQ_STAT = 8'hA0;
    localparam logic [7:0] ICC_IDX_IRQ_MASK = 8'hA1;
    // Field positions
    localparam int ICC_EN_LSB = 4;
    localparam int ICC_FLAG_LSB = 0;
    localparam int ICC_FILT_LSB = 4;
    localparam int ICC_KIND_W = 2;
    // Reset values
    localparam logic [2:0] ICC_EN_RST = 3'h0;
    localparam logic [2:0] ICC_FLAG_RST = 3'h0;
    localparam logic [5:0] ICC_EDGE_RST = 6'h00;
    localparam logic [2:0] ICC_FILT_RST = 3'h0;
    localparam logic [2:0] ICC_IRQ_RST = 3'h0;
    // Noise filter: samples a new level must hold before it is accepted
    localparam int ICC_FILT_LEN = 4;
    localparam int ICC_FILT_CNT_W = 3;

    typedef enum logic [1:0] {
        ICC_EDGE_FALL = 2'b00,
        ICC_EDGE_RISE = 2'b01,
        ICC_EDGE_BOTH = 2'b10,
        ICC_EDGE_RSVD = 2'b11
    } icc_edge_type;

    typedef struct packed {
        logic on;
        logic filter_on;
        icc_edge_type kind;
    } icc_chan_cfg_type;
endpackage

//--- test/icc_pin_model.sv
// Purpose: Far-side model of the three capture pins
// Assumes: Pins are driven push-pull, no pull resistors
// Notes: Slow mode delays every level change by one more cycle
`timescale 1ns/1ps
module icc_pin_model (
    input wire logic clock,
    input wire logic slow,
    input wire logic [2:0] want,
    output logic [2:0] cap_in
);
    logic [2:0] late_q;
    initial begin
        late_q = 3'h0;
        cap_in = 3'h0;
    end
    // Levels only move on clock edges, like a synchronous pin driver
    always @(posedge clock) begin
        late_q <= want;
        cap_in <= slow ? late_q : want;
    end
endmodule

//--- test/input_capture_control_test.sv
// Purpose: Self-checking bench for the input capture control block
// Assumes: Default filter length of four samples
// Notes: Register byte address is four times the register index
`timescale 1ns/1ps
module input_capture_control_test;
    import icc_pkg::*;
    logic clock, rst, avs_read, avs_write, avs_waitrequest, irq, slow;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [2:0] cap_in, cap_event, want;
    int num_errors, checked;
    int ev_cnt [3];
    localparam logic [9:0] A_EN = 10'h248, A_EDGE = 10'h24C, A_FILT = 10'h250;
    localparam logic [9:0] A_STAT = 10'h280, A_MASK = 10'h284;

    icc_input_capture icc_input_capture_inst (.clock(clock), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cap_in(cap_in), .cap_event(cap_event), .irq(irq));
    icc_pin_model icc_pin_model_inst (.clock(clock), .slow(slow), .want(want),
        .cap_in(cap_in));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        for (int i = 0; i < 3; i++) begin
            if (cap_event[i] === 1'b1) ev_cnt[i]++;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
        bus_rd(a, rd);
        check(name, rd, exp);
    endtask

    task automatic pins(input logic [2:0] v, input int n);
        want <= v;
        repeat (n) @(posedge clock);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 10'h000;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        want = 3'h0;
        slow = 1'b0;
        num_errors = 0;
        checked = 0;
        ev_cnt = '{0, 0, 0};
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd_chk("enflag reset", A_EN, 32'h0000_0000);
        rd_chk("edge reset", A_EDGE, 32'h0000_0000);
        rd_chk("filter reset", A_FILT, 32'h0000_0000);
        // Ch2 either edge, ch1 rising, ch0 falling; code 11 never written
        bus_wr(A_EDGE, 32'h0000_00E4);
        rd_chk("edge fields", A_EDGE, 32'h0000_0024);
        // Lane 0 off: write answered but ignored
        avs_byteenable <= 4'h0;
        bus_wr(A_EDGE, 32'h0000_0015);
        avs_byteenable <= 4'hF;
        rd_chk("edge lane off", A_EDGE, 32'h0000_0024);
        bus_wr(A_FILT, 32'h0000_0040);
        rd_chk("filter bits", A_FILT, 32'h0000_0040);
        bus_wr(A_EN, 32'h0000_0070);
        bus_wr(A_MASK, 32'h0000_0007);
        pins(3'h7, 20);
        rd_chk("rise flags", A_EN, 32'h0000_0076);
        check("irq set", {31'h0, irq}, 32'h1);
        bus_wr(A_EN, 32'h0000_0070);
        rd_chk("flags cleared", A_EN, 32'h0000_0070);
        slow <= 1'b1;
        pins(3'h0, 20);
        rd_chk("fall flags", A_EN, 32'h0000_0075);
        bus_wr(A_EN, 32'h0000_0077);
        pins(3'h0, 40);
        rd_chk("flags sticky", A_EN, 32'h0000_0075);
        bus_wr(A_MASK, 32'h0000_0000);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus_wr(A_MASK, 32'h0000_0007);
        rd_chk("stat bits", A_STAT, 32'h0000_0007);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        bus_wr(A_STAT, 32'h0000_0007);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk("stat cleared", A_STAT, 32'h0000_0000);
        bus_wr(A_EN, 32'h0000_0070);
        // Three-cycle glitch passes unfiltered ch1, not filtered ch2
        pins(3'h6, 3);
        pins(3'h0, 20);
        rd_chk("glitch flags", A_EN, 32'h0000_0072);
        bus_wr(A_EN, 32'h0000_0000);
        pins(3'h7, 20);
        pins(3'h0, 20);
        rd_chk("disabled", A_EN, 32'h0000_0000);
        rd_chk("unmapped", 10'h254, 32'h0000_0000);
        check("ch0 events", ev_cnt[0], 32'd1);
        check("ch1 events", ev_cnt[1], 32'd2);
        check("ch2 events", ev_cnt[2], 32'd2);
        close_out();
    end
endmodule
